//--- can_regs_pkg.sv
// Constants and types shared by the CAN mask, data window and timer block
package can_regs_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TIMER_PRESCALE = 8'hA1;
    localparam logic [7:0] ADDR_DATA_WINDOW    = 8'hA3;
    localparam logic [7:0] ADDR_TRIG_LOW       = 8'hA4;
    localparam logic [7:0] ADDR_TRIG_HIGH      = 8'hA5;
    localparam logic [7:0] ADDR_MSG_TIM_LOW    = 8'hAC;
    localparam logic [7:0] ADDR_MSG_TIM_HIGH   = 8'hAD;
    localparam logic [7:0] ADDR_STAMP_LOW      = 8'hAE;
    localparam logic [7:0] ADDR_STAMP_HIGH     = 8'hAF;
    localparam logic [7:0] ADDR_MASK_ONE       = 8'hC4;
    localparam logic [7:0] ADDR_MASK_TWO       = 8'hC5;
    localparam logic [7:0] ADDR_MASK_THREE     = 8'hC6;
    localparam logic [7:0] ADDR_MASK_FOUR      = 8'hC7;

    // ------------------------------------------------------------
    // Sizes, fields and reset values
    // ------------------------------------------------------------
    localparam int          MBOX_NUM          = 15;
    localparam logic [3:0]  MBOX_LAST         = 4'hE;
    localparam int          MBOX_BYTES        = 8;
    localparam int          MASK_REGS         = 4;
    localparam int          MASK4_REMOTE_BIT  = 2;
    localparam int          MASK4_EXT_BIT     = 0;
    localparam logic [7:0]  MASK4_WRITABLE    = 8'hFD;
    localparam logic [7:0]  PRESCALE_RESET    = 8'h00;
    localparam logic [15:0] TIMER_RESET       = 16'h0000;
    localparam logic [7:0]  RDATA_RESET       = 8'h00;
    localparam logic [2:0]  INDEX_RESET       = 3'h0;
    localparam logic [3:0]  MBOX_RESET        = 4'h0;
    localparam logic [2:0]  INDEX_ONE         = 3'h1;
    localparam logic [7:0]  PREDIV_ONE        = 8'h01;
    localparam logic [15:0] TIMER_ONE         = 16'h0001;

    // Filter result word: {hit, mailbox}
    localparam int          RES_W             = 5;

    typedef logic [7:0] byte_t;

endpackage

//--- two_entry_buffer.sv
// Two-entry valid/ready buffer for filter results
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int W = can_regs_pkg::RES_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    import can_regs_pkg::*;

    typedef struct packed {
        logic [1:0][W-1:0] slot;
        logic [1:0]        cnt;
    } buf_state_t;

    buf_state_t st_ff;
    buf_state_t nxt_st;
    logic       push;
    logic       pop;

    assign in_ready  = (st_ff.cnt != 2'h2);
    assign out_valid = (st_ff.cnt != 2'h0);
    assign out_data  = st_ff.slot[0];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (pop) begin
            nxt_st.slot[0] = st_ff.slot[1];
        end
        if (push) begin
            // Land in the first free slot after any pop this cycle
            if (st_ff.cnt == 2'h0 || (st_ff.cnt == 2'h1 && pop)) begin
                nxt_st.slot[0] = in_data;
            end else begin
                nxt_st.slot[1] = in_data;
            end
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

//--- can_mask_data_timer_regs.sv
// CAN acceptance masks, mailbox data window and CAN timers behind the SFR port
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module can_mask_data_timer_regs (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           sfr_addr,
    input  wire can_regs_pkg::byte_t  sfr_wdata,
    input  wire logic                 sfr_wr,
    input  wire logic                 sfr_rd,
    output can_regs_pkg::byte_t       sfr_rdata,
    input  wire logic                 page_wr,
    input  wire logic [3:0]           page_mbox,
    input  wire logic [2:0]           page_idx,
    input  wire logic                 auto_inc_en,
    input  wire logic                 stamp_capture,
    input  wire logic                 ttc_clear,
    input  wire logic                 flt_valid,
    output logic                      flt_ready,
    input  wire logic                 flt_tx,
    input  wire logic [3:0]           flt_mbox,
    input  wire logic                 flt_ext,
    input  wire logic [28:0]          rx_id,
    input  wire logic                 rx_rtr,
    input  wire logic                 rx_ide,
    input  wire logic [28:0]          tag_id,
    input  wire logic                 tag_rtr,
    input  wire logic                 tag_ide,
    output logic                      res_valid,
    input  wire logic                 res_ready,
    output logic [3:0]                res_mbox,
    output logic                      res_hit
);
    import can_regs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        byte_t       prescale;
        byte_t       prediv;
        logic [15:0] msg_tim;
        logic [15:0] trig_tim;
        logic [3:0]  ptr_mbox;
        logic [2:0]  ptr_idx;
        byte_t       rdata;
    } ctl_state_t;

    // Storage without reset: contents stay undefined until software writes, or for stamp until a stamp_capture
    typedef struct packed {
        logic [MBOX_NUM-1:0][MASK_REGS-1:0][7:0]  mask;
        logic [MBOX_NUM-1:0][MBOX_BYTES-1:0][7:0] data;
        logic [15:0]                              stamp;
    } store_state_t;

    ctl_state_t   ctl_ff;
    ctl_state_t   nxt_ctl;
    store_state_t store_ff;
    store_state_t nxt_store;

    logic        tick;
    logic        win_access;
    logic        ptr_ok;
    logic        flt_ok;
    logic [28:0] id_mask;
    logic        rtr_mask;
    logic        ide_mask;
    logic [28:0] id_diff;
    logic        cmp_hit;
    logic        res_in_valid;
    logic        res_in_ready;
    logic [RES_W-1:0] res_word;
    byte_t       rd_mux;

    // ------------------------------------------------------------
    // Timer tick
    // ------------------------------------------------------------
    assign tick = (ctl_ff.prediv == ctl_ff.prescale);

    assign win_access = (sfr_wr || sfr_rd) && (sfr_addr == ADDR_DATA_WINDOW);
    assign ptr_ok     = (ctl_ff.ptr_mbox <= MBOX_LAST);
    assign flt_ok     = (flt_mbox <= MBOX_LAST);

    // ------------------------------------------------------------
    // Acceptance compare
    // ------------------------------------------------------------
    always_comb begin
        id_mask  = '0;
        rtr_mask = 1'b0;
        ide_mask = 1'b0;
        if (flt_ok) begin
            if (flt_ext) begin
                id_mask = {store_ff.mask[flt_mbox][0], store_ff.mask[flt_mbox][1],
                           store_ff.mask[flt_mbox][2],
                           store_ff.mask[flt_mbox][3][7:3]};
            end else begin
                id_mask[10:0] = {store_ff.mask[flt_mbox][0],
                                 store_ff.mask[flt_mbox][1][7:5]};
            end
            rtr_mask = store_ff.mask[flt_mbox][3][MASK4_REMOTE_BIT];
            ide_mask = store_ff.mask[flt_mbox][3][MASK4_EXT_BIT];
        end
    end

    assign id_diff = (rx_id ^ tag_id) & id_mask;
    // Transmit lookups bypass the masks entirely
    assign cmp_hit = flt_tx ? 1'b1
                   : (id_diff == '0)
                     && !(rtr_mask && (rx_rtr != tag_rtr))
                     && !(ide_mask && (rx_ide != tag_ide));

    assign res_in_valid = flt_valid;
    assign flt_ready    = res_in_ready;
    assign res_word     = {cmp_hit && flt_ok, flt_mbox};

    // ------------------------------------------------------------
    // Result buffer: once two results wait, a stalled consumer holds the filter source
    // ------------------------------------------------------------
    two_entry_buffer #(
        .W (RES_W)
    ) result_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (res_in_valid),
        .in_ready  (res_in_ready),
        .in_data   (res_word),
        .out_valid (res_valid),
        .out_ready (res_ready),
        .out_data  ({res_hit, res_mbox})
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = RDATA_RESET;
        case (sfr_addr)
            ADDR_TIMER_PRESCALE: rd_mux = ctl_ff.prescale;
            ADDR_DATA_WINDOW: begin
                if (ptr_ok) begin
                    rd_mux = store_ff.data[ctl_ff.ptr_mbox][ctl_ff.ptr_idx];
                end
            end
            ADDR_TRIG_LOW:     rd_mux = ctl_ff.trig_tim[7:0];
            ADDR_TRIG_HIGH:    rd_mux = ctl_ff.trig_tim[15:8];
            ADDR_MSG_TIM_LOW:  rd_mux = ctl_ff.msg_tim[7:0];
            ADDR_MSG_TIM_HIGH: rd_mux = ctl_ff.msg_tim[15:8];
            ADDR_STAMP_LOW:    rd_mux = store_ff.stamp[7:0];
            ADDR_STAMP_HIGH:   rd_mux = store_ff.stamp[15:8];
            ADDR_MASK_ONE, ADDR_MASK_TWO, ADDR_MASK_THREE: begin
                if (ptr_ok) begin
                    rd_mux = store_ff.mask[ctl_ff.ptr_mbox][sfr_addr[1:0]];
                end
            end
            ADDR_MASK_FOUR: begin
                // Reserved bit reads zero, a legal reading of undefined
                if (ptr_ok) begin
                    rd_mux = store_ff.mask[ctl_ff.ptr_mbox][3] & MASK4_WRITABLE;
                end
            end
            default: rd_mux = RDATA_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // Next state: control
    // ------------------------------------------------------------
    always_comb begin
        nxt_ctl = ctl_ff;
        if (tick) begin
            nxt_ctl.prediv   = PRESCALE_RESET;
            nxt_ctl.msg_tim  = ctl_ff.msg_tim + TIMER_ONE;
            nxt_ctl.trig_tim = ctl_ff.trig_tim + TIMER_ONE;
        end else begin
            nxt_ctl.prediv = ctl_ff.prediv + PREDIV_ONE;
        end
        if (ttc_clear) begin
            nxt_ctl.trig_tim = TIMER_RESET;
        end
        if (sfr_wr && sfr_addr == ADDR_TIMER_PRESCALE) begin
            nxt_ctl.prescale = sfr_wdata;
            // Restart the divider so a smaller value cannot be overrun
            nxt_ctl.prediv   = PRESCALE_RESET;
        end
        if (sfr_rd) begin
            nxt_ctl.rdata = rd_mux;
        end
        // Page write wins over a same-cycle window step
        if (page_wr) begin
            nxt_ctl.ptr_mbox = page_mbox;
            nxt_ctl.ptr_idx  = page_idx;
        end else if (win_access && auto_inc_en) begin
            nxt_ctl.ptr_idx = ctl_ff.ptr_idx + INDEX_ONE;
        end
    end

    // ------------------------------------------------------------
    // Next state: storage
    // ------------------------------------------------------------
    always_comb begin
        nxt_store = store_ff;
        if (stamp_capture) begin
            nxt_store.stamp = ctl_ff.msg_tim;
        end
        if (sfr_wr && ptr_ok) begin
            case (sfr_addr)
                ADDR_DATA_WINDOW: begin
                    nxt_store.data[ctl_ff.ptr_mbox][ctl_ff.ptr_idx] = sfr_wdata;
                end
                ADDR_MASK_ONE, ADDR_MASK_TWO, ADDR_MASK_THREE: begin
                    nxt_store.mask[ctl_ff.ptr_mbox][sfr_addr[1:0]] = sfr_wdata;
                end
                ADDR_MASK_FOUR: begin
                    nxt_store.mask[ctl_ff.ptr_mbox][3] = sfr_wdata & MASK4_WRITABLE;
                end
                default: begin
                    nxt_store.stamp = nxt_store.stamp;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_ff.prescale <= PRESCALE_RESET;
            ctl_ff.prediv   <= PRESCALE_RESET;
            ctl_ff.msg_tim  <= TIMER_RESET;
            ctl_ff.trig_tim <= TIMER_RESET;
            ctl_ff.ptr_mbox <= MBOX_RESET;
            ctl_ff.ptr_idx  <= INDEX_RESET;
            ctl_ff.rdata    <= RDATA_RESET;
        end else begin
            ctl_ff <= nxt_ctl;
        end
    end

    // No reset on masks, data and stamp
    always_ff @(posedge clk) begin
        store_ff <= nxt_store;
    end

    assign sfr_rdata = ctl_ff.rdata;
endmodule

//--- can_regs_assertions.sv
// Assertion checker for the CAN mask, data window and timer block
`timescale 1ns/1ps
module can_regs_assertions (
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [7:0]          sfr_addr,
    input wire can_regs_pkg::byte_t sfr_wdata,
    input wire logic                sfr_wr,
    input wire logic                sfr_rd,
    input wire can_regs_pkg::byte_t sfr_rdata,
    input wire logic                page_wr,
    input wire logic                flt_valid,
    input wire logic                flt_ready,
    input wire logic                flt_tx,
    input wire logic [3:0]          flt_mbox,
    input wire logic                res_valid,
    input wire logic                res_ready,
    input wire logic [3:0]          res_mbox,
    input wire logic                res_hit
);
    import can_regs_pkg::*;
    wire mapped = sfr_addr inside {8'hA1, [8'hA3:8'hA5], [8'hAC:8'hAF], [8'hC4:8'hC7]};
    // Empty buffer, so the request shows at the head next cycle
    wire taken  = flt_valid && flt_ready && !res_valid;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Write, one quiet cycle, then a read of the same place
    sequence s_back(w);
        w && sfr_wr ##1 !sfr_wr && !page_wr
        ##1 sfr_rd && !sfr_wr && !page_wr && sfr_addr == $past(sfr_addr, 2);
    endsequence
    property p_hold;
        !sfr_rd |=> $stable(sfr_rdata);
    endproperty
    property p_unmapped;
        sfr_rd && !mapped |=> sfr_rdata == 8'h00;
    endproperty
    property p_rw_back;
        s_back(sfr_addr inside {8'hA1, [8'hC4:8'hC6]}) |=> sfr_rdata == $past(sfr_wdata, 3);
    endproperty
    property p_mask4;
        s_back(sfr_addr == 8'hC7) |=> sfr_rdata == ($past(sfr_wdata, 3) & MASK4_WRITABLE);
    endproperty
    property p_tx;
        taken && flt_tx && flt_mbox != 4'hF |=> res_valid && res_hit && res_mbox == $past(flt_mbox);
    endproperty
    property p_bad_mbox;
        taken && flt_mbox == 4'hF |=> res_valid && !res_hit;
    endproperty
    property p_stand;
        res_valid && !res_ready |=> res_valid && $stable(res_hit) && $stable(res_mbox);
    endproperty
    property p_cause;
        $rose(res_valid) |-> $past(flt_valid) && $past(flt_ready);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rw_back: assert property (p_rw_back) else $error("register readback wrong");
    a_mask4: assert property (p_mask4) else $error("mask four readback wrong");
    a_tx: assert property (p_tx) else $error("transmit lookup not a hit");
    a_bad_mbox: assert property (p_bad_mbox) else $error("invalid mailbox hit");
    a_stand: assert property (p_stand) else $error("result changed while stalled");
    a_cause: assert property (p_cause) else $error("result without request");
endmodule
bind can_mask_data_timer_regs can_regs_assertions chk (
    .clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .page_wr, .flt_valid,
    .flt_ready, .flt_tx, .flt_mbox, .res_valid, .res_ready, .res_mbox, .res_hit
);

//--- can_mask_data_timer_regs_test.sv
// Self-checking bench for the CAN mask, data window and timer block
`timescale 1ns/1ps
module can_mask_data_timer_regs_test;
    import can_regs_pkg::*;
    logic        clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, page_wr = 0, auto_inc_en = 1;
    logic        stamp_capture = 0, ttc_clear = 0, flt_valid = 0, flt_tx = 0, flt_ext = 0;
    logic        rx_rtr = 0, rx_ide = 0, tag_rtr = 0, tag_ide = 0, res_ready = 0, hold = 1;
    logic        flt_ready, res_valid, res_hit;
    logic [7:0]  sfr_addr = 0;
    byte_t       sfr_wdata = 0, sfr_rdata;
    logic [3:0]  page_mbox = 0, flt_mbox = 0, res_mbox;
    logic [2:0]  page_idx = 0;
    logic [28:0] rx_id = 0, tag_id = 0;
    logic [31:0] seed = 32'h749872A0;
    int          fail_count = 0, comparisons = 0, mb = 0, ix = 0, cnt = 0;
    byte_t       mem [16][8];
    byte_t       msk [16][4];
    logic [4:0]  q [$];
    can_mask_data_timer_regs uut (.clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
        .sfr_rdata, .page_wr, .page_mbox, .page_idx, .auto_inc_en, .stamp_capture, .ttc_clear,
        .flt_valid, .flt_ready, .flt_tx, .flt_mbox, .flt_ext, .rx_id, .rx_rtr, .rx_ide,
        .tag_id, .tag_rtr, .tag_ide, .res_valid, .res_ready, .res_mbox, .res_hit);
    initial forever #2.5 clk = ~clk;
    // ------------------------------------------------------------
    // Model and helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [4:0] expect_res(logic [3:0] m);
        logic [28:0] k;
        logic        h;
        k = flt_ext ? {msk[m][0], msk[m][1], msk[m][2], msk[m][3][7:3]}
                    : {18'h0, msk[m][0], msk[m][1][7:5]};
        h = ((rx_id ^ tag_id) & k) == 0 && !(msk[m][3][2] && rx_rtr != tag_rtr)
            && !(msk[m][3][0] && rx_ide != tag_ide);
        return {m != 4'hF && (flt_tx || h), m};
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string n, byte_t e, byte_t s);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chkr(logic [4:0] e, logic [4:0] s);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("BAD filter expected %h seen %h", e, s);
        end
    endtask
    task automatic page(logic [3:0] m, logic [2:0] i);
        @(negedge clk);
        {page_wr, page_mbox, page_idx} = {1'b1, m, i};
        @(negedge clk);
        page_wr = 0;
        mb = m;
        ix = i;
    endtask
    task automatic wr(logic [7:0] a, byte_t d);
        @(negedge clk);
        {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
        @(negedge clk);
        sfr_wr = 0;
        if (mb < 15 && a == 8'hA3) mem[mb][ix] = d;
        if (mb < 15 && a inside {[8'hC4:8'hC7]}) msk[mb][a[1:0]] = d;
        if (a == 8'hA3 && auto_inc_en) ix = (ix + 1) % 8;
    endtask
    task automatic rdv(logic [7:0] a, output byte_t v);
        @(negedge clk);
        {sfr_rd, sfr_addr} = {1'b1, a};
        @(negedge clk);
        sfr_rd = 0;
        v = sfr_rdata;
        if (a == 8'hA3 && auto_inc_en) ix = (ix + 1) % 8;
    endtask
    task automatic rd(string n, logic [7:0] a, byte_t e);
        byte_t v;
        rdv(a, v);
        chk(n, e, v);
    endtask
    task automatic push();
        int k;
        @(negedge clk);
        flt_valid = 1;
        for (k = 0; k < 50 && flt_ready !== 1; k++) @(negedge clk);
        if (k == 50) begin
            fail_count++;
            tally_and_finish();
        end
        q.push_back(expect_res(flt_mbox));
        @(negedge clk);
        flt_valid = 0;
    endtask
    task automatic drain();
        int k;
        for (k = 0; k < 300 && q.size() > 0; k++) @(negedge clk);
        if (q.size() > 0) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    // Consumer stalls two cycles in three to keep results queued
    // Ready is set first, so the check sees the pair that the next rising edge takes
    always @(negedge clk) begin
        cnt = cnt + 1;
        res_ready = !hold && cnt % 3 == 0;
        if (res_valid === 1 && res_ready === 1) chkr(q.pop_front(), {res_hit, res_mbox});
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        byte_t v, t;
        int    i, r, p;
        repeat (3) @(negedge clk);
        rst = 0;
        rd("prescale", 8'hA1, 8'h00);
        rd("timer_high", 8'hAD, 8'h00);
        rd("trig_high", 8'hA5, 8'h00);
        for (i = 0; i < 15; i++) begin
            page(4'(i), 3'(rnd()));
            for (r = 0; r < 4; r++) begin
                wr(8'(8'hC4 + r), 8'(rnd()) & (r == 3 ? 8'hFD : 8'hFF));
                rd("mask", 8'(8'hC4 + r), msk[i][r]);
            end
            for (r = 0; r < 10; r++) wr(8'hA3, 8'(rnd()));
        end
        for (i = 0; i < 15; i++) begin
            page(4'(i), 3'(i));
            for (r = 0; r < 9; r++) rd("window", 8'hA3, mem[mb][ix]);
        end
        auto_inc_en = 0;
        page(4'h3, 3'h5);
        repeat (2) rd("window_hold", 8'hA3, mem[3][5]);
        auto_inc_en = 1;
        wr(8'hA2, 8'h5A);
        rd("unmapped", 8'hA2, 8'h00);
        page(4'hF, 3'h0);
        rd("bad_mailbox", 8'hA3, 8'h00);
        hold = 0;
        for (i = 0; i < 60; i++) begin
            flt_mbox = 4'(rnd());
            {flt_ext, rx_rtr, rx_ide, tag_rtr, tag_ide} = 5'(rnd());
            flt_tx = &2'(rnd());
            rx_id = 29'(rnd());
            tag_id = rx_id ^ (29'(rnd()) & 29'(rnd()) & 29'(rnd()) & 29'(rnd()));
            push();
        end
        drain();
        hold = 1;
        flt_tx = 1;
        repeat (3) @(negedge clk);
        for (i = 1; i < 3; i++) begin
            flt_mbox = 4'(i);
            push();
        end
        chk("ready_full", 8'h00, {7'h0, flt_ready});
        hold = 0;
        drain();
        for (i = 0; i < 3; i++) begin
            p = i == 0 ? 0 : (i == 1 ? 3 : 255);
            wr(8'hA1, 8'(p));
            rd("prescale", 8'hA1, 8'(p));
            for (r = 0; r < 2; r++) begin
                rdv(r ? 8'hA4 : 8'hAC, t);
                wr(r ? 8'hA4 : 8'hAC, 8'h5A);
                repeat (8 * (p + 1) - 4) @(negedge clk);
                rdv(r ? 8'hA4 : 8'hAC, v);
                chk("timer_step", t + 8'h08, v);
            end
        end
        // Fresh divider, so no tick lands before the reads below
        wr(8'hA1, 8'hFF);
        @(negedge clk);
        {stamp_capture, ttc_clear} = 2'b11;
        @(negedge clk);
        {stamp_capture, ttc_clear} = 2'b00;
        rdv(8'hAC, t);
        rdv(8'hAD, v);
        rd("stamp_low", 8'hAE, t);
        rd("stamp_high", 8'hAF, v);
        rd("trig_low", 8'hA4, 8'h00);
        tally_and_finish();
    end
endmodule
